// *** dv/flc_flash_model.sv ***
// behavioural parallel flash device facing the host controller
`timescale 1ns/1ns
module flc_flash_model #(
   parameter int PROG_CYC = 100,
   parameter int ERASE_CYC = 300,
   parameter int WIN_CYC = 200,
   // identification codes, values arbitrary
   parameter logic [7:0] MFR_CODE = 8'h36,
   parameter logic [7:0] DEV_CODE = 8'h5e
) (
   // clock
   input wire logic clk_sys_i,
   // pins driven by the host
   input wire logic [18:0] addr_i,
   input wire logic [7:0] dq_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   // data pins towards the host
   output logic [7:0] dq_o
);
   logic [7:0] mem [0:2047];
   logic [7:0] sel = 8'h00;
   logic [7:0] pdat = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] drv;
   logic [10:0] ad;
   logic we_q = 1'b1;
   logic oe_q = 1'b1;
   logic tog = 1'b0;
   logic chip = 1'b0;
   logic susp = 1'b0;
   logic asel = 1'b0;
   int step = 0;
   int pcnt = 0;
   int ecnt = 0;
   int wcnt = 0;
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
   ////////////////////////////////////////////////////////////////////////////
   // status while busy; released pins show the inverse, no pull on the bus
   always_comb begin
      ad = {addr_i[18:16], addr_i[7:0]};
      // identification codes answer even inside erasing sectors
      if (asel)
         drv = addr_i[0] ? DEV_CODE : MFR_CODE;
      else if (pcnt > 0)
         drv = {~pdat[7], tog, 6'h00};
      else if (((ecnt > 0 || wcnt > 0) && !susp) || (susp && sel[addr_i[18:16]]))
         drv = {susp, tog & ~susp, 2'b00, wcnt == 0, tog, 2'b00};
      else
         drv = mem[ad];
      dq_o = (!ce_n_i && !oe_n_i) ? drv : ~last;
   end
   ////////////////////////////////////////////////////////////////////////////
   // internal timers, then commands taken on the rising write strobe
   always @(posedge clk_sys_i) begin
      we_q <= we_n_i;
      oe_q <= oe_n_i;
      if (!ce_n_i && !oe_n_i) last <= drv;
      if (!oe_q && oe_n_i) tog <= ~tog;
      if (pcnt > 0) pcnt <= pcnt - 1;
      if (!susp && wcnt == 1) ecnt <= ERASE_CYC;
      if (!susp && wcnt > 0) wcnt <= wcnt - 1;
      if (!susp && ecnt > 0) ecnt <= ecnt - 1;
      if (!susp && ecnt == 1) begin
         // preprogram to zero then erase: net result all ones
         for (int i = 0; i < 2048; i++) if (sel[i / 256]) mem[i] <= 8'hff;
         sel <= 8'h00;
         chip <= 1'b0;
      end
      if (!we_q && we_n_i && !ce_n_i) begin
         if (asel) begin
            asel <= (dq_i != 8'hf0); // reset leaves id mode, suspend kept
         end else if (pcnt > 0 || chip || (ecnt > 0 && !susp)) begin
            // running algorithm: only suspend, and only in sector erase
            if (dq_i == 8'hb0 && !chip && pcnt == 0) susp <= 1'b1;
         end else if (step == 6) begin
            mem[ad] <= mem[ad] & dq_i;
            pdat <= dq_i;
            pcnt <= PROG_CYC;
            step <= 0;
         end else if (wcnt > 0) begin
            // window: add sector, suspend at once, or abort
            if (dq_i == 8'h30) sel[addr_i[18:16]] <= 1'b1;
            wcnt <= (dq_i == 8'h30) ? WIN_CYC : 0;
            if (dq_i == 8'hb0) susp <= 1'b1;
            if (dq_i == 8'hb0) ecnt <= ERASE_CYC;
            if (dq_i != 8'h30 && dq_i != 8'hb0) sel <= 8'h00;
         end else if (susp && dq_i == 8'h30) begin
            susp <= 1'b0;
         end else begin
            // unlock pair and set-up, upper address bits ignored
            case (step)
               0: step <= (addr_i[10:0] == 11'h555 && dq_i == 8'haa) ? 1 : 0;
               1: step <= (addr_i[10:0] == 11'h2aa && dq_i == 8'h55) ? 2 : 0;
               2: begin
                  step <= (dq_i == 8'ha0) ? 6 : (dq_i == 8'h80) ? 3 : 0;
                  if (dq_i == 8'h90) asel <= 1'b1;
               end
               3: step <= (dq_i == 8'haa) ? 4 : 0;
               4: step <= (dq_i == 8'h55) ? 5 : 0;
               default: begin
                  step <= 0;
                  chip <= (dq_i == 8'h10);
                  if (dq_i == 8'h10) sel <= 8'hff;
                  if (dq_i == 8'h10) ecnt <= ERASE_CYC;
                  if (dq_i == 8'h30) sel[addr_i[18:16]] <= 1'b1;
                  if (dq_i == 8'h30) wcnt <= WIN_CYC;
               end
            endcase
         end
      end
   end
endmodule : flc_flash_model

// *** dv/flc_host_bench.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module flc_host_bench;
   typedef struct packed {logic [18:0] a; logic [7:0] d; logic [7:0] e;} flc_row_t;
   flc_row_t rows [4] = '{'{19'h00010, 8'h5a, 8'h5a}, '{19'h70020, 8'h0f, 8'h0f},
      '{19'h70020, 8'hf3, 8'h03}, '{19'h10030, 8'h81, 8'h81}};
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [31:0] reg_wdata_i = 32'h00000000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o, rd_v;
   logic [18:0] fl_addr_o;
   logic [7:0] fl_dq_o, fl_dq_i;
   logic fl_dq_oe_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o;
   int err_total = 0;
   int comparisons = 0;
   initial forever #5 clk_sys_i = ~clk_sys_i;
   // short window keeps the run brief
   flc_host #(.WIN_CYC(200)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o),
      .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(fl_dq_i),
      .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
   flc_flash_model #(.WIN_CYC(200)) flash (.clk_sys_i(clk_sys_i), .addr_i(fl_addr_o),
      .dq_i(fl_dq_o), .ce_n_i(fl_ce_n_o), .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o),
      .dq_o(fl_dq_i));
   ////////////////////////////////////////////////////////////////////////////
   // register port cycles and flash operations
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 rd_v = reg_rdata_o;
   endtask : rd
   task automatic report_and_stop();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // busy clears within the suspend wait, so this bound covers every case
   task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
      wr(flc_pkg::OFF_ADDR, {13'h0000, a});
      wr(flc_pkg::OFF_WDATA, {24'h000000, d});
      wr(flc_pkg::OFF_CMD, {28'h0000000, c});
      for (int i = 0; i < 3000; i++) begin
         rd(flc_pkg::OFF_STAT);
         if (rd_v[flc_pkg::ST_BUSY] === 1'b0) return;
      end
      err_total++;
      report_and_stop();
   endtask : op
   task automatic poll(input logic [18:0] a, input logic [7:0] e);
      for (int i = 0; i < 100; i++) begin
         op(flc_pkg::OP_READ, a, 8'h00);
         rd(flc_pkg::OFF_RDATA);
         if (rd_v[7:0] === e) return;
      end
      err_total++;
      report_and_stop();
   endtask : poll
   initial begin
      #500000;
      err_total++; // a hang counts as a mismatch
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////////
   // table of programs, then erase, suspend and refusal cases
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(flc_pkg::OFF_STAT);
      `CHK("stat after reset", 32'h00000000, rd_v)
      rd(5'h1c);
      `CHK("unmapped", 32'h00000000, rd_v)
      foreach (rows[i]) begin
         op(flc_pkg::OP_PROG, rows[i].a, rows[i].d);
         op(flc_pkg::OP_READ, rows[i].a, 8'h00);
         rd(flc_pkg::OFF_RDATA);
         `CHK("busy poll", ~rows[i].d[7], rd_v[7])
         poll(rows[i].a, rows[i].e);
         `CHK("program", rows[i].e, rd_v[7:0])
      end
      op(flc_pkg::OP_SECT, 19'h00000, 8'h00);
      op(flc_pkg::OP_RESET, 19'h00000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("abort", 2'b00, {rd_v[flc_pkg::ST_SECT], rd_v[flc_pkg::ST_WIN]})
      op(flc_pkg::OP_SECT, 19'h10000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("window", 1'b1, rd_v[flc_pkg::ST_WIN])
      op(flc_pkg::OP_ADDS, 19'h70000, 8'h00);
      op(flc_pkg::OP_SUSP, 19'h00000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("suspended", 1'b1, rd_v[flc_pkg::ST_SUSP])
      op(flc_pkg::OP_AUTOSEL, 19'h00000, 8'h00);
      op(flc_pkg::OP_READ, 19'h10001, 8'h00);
      rd(flc_pkg::OFF_RDATA);
      `CHK("id code", flash.DEV_CODE, rd_v[7:0])
      op(flc_pkg::OP_RESET, 19'h00000, 8'h00);
      op(flc_pkg::OP_READ, 19'h10030, 8'h00);
      rd(flc_pkg::OFF_RDATA);
      `CHK("suspended sector status", 5'b10001, rd_v[7:3])
      op(flc_pkg::OP_PROG, 19'h20041, 8'h11);
      poll(19'h20041, 8'h11);
      `CHK("suspend program", 8'h11, rd_v[7:0])
      op(flc_pkg::OP_RESUME, 19'h00000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("resumed", 1'b0, rd_v[flc_pkg::ST_SUSP])
      op(flc_pkg::OP_SUSP, 19'h00000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("second suspend", 1'b1, rd_v[flc_pkg::ST_SUSP])
      op(flc_pkg::OP_RESUME, 19'h00000, 8'h00);
      poll(19'h10030, 8'hff);
      `CHK("erased", 8'hff, rd_v[7:0])
      poll(19'h70020, 8'hff);
      `CHK("added sector", 8'hff, rd_v[7:0])
      poll(19'h00010, 8'h5a);
      `CHK("kept sector", 8'h5a, rd_v[7:0])
      op(flc_pkg::OP_CHIP, 19'h00000, 8'h00);
      op(flc_pkg::OP_SUSP, 19'h00000, 8'h00);
      rd(flc_pkg::OFF_STAT);
      `CHK("refused suspend", 1'b1, rd_v[flc_pkg::ST_ERR])
      poll(19'h20041, 8'hff);
      `CHK("chip erased", 8'hff, rd_v[7:0])
      report_and_stop();
   end
endmodule : flc_host_bench

// *** verilog/flc_bus_cyc.sv ***
// flash pin engine: one write or read bus cycle per request
`timescale 1ns/1ns
module flc_bus_cyc (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // sequencer side
   flc_cyc_if.engine cyc,
   // flash pins
   output logic [18:0] fl_addr_o,
   output logic [7:0] fl_dq_o,
   output logic fl_dq_oe_o,
   input wire logic [7:0] fl_dq_i,
   output logic fl_ce_n_o,
   output logic fl_we_n_o,
   output logic fl_oe_n_o
);

   typedef enum logic [1:0] {E_IDLE, E_SET, E_STB, E_HOLD} flc_eng_t;

   flc_eng_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt;
   logic [18:0] addr_nxt;
   logic [7:0] dq_nxt, rdata_nxt;
   logic dq_oe_nxt, ce_n_nxt, we_n_nxt, oe_n_nxt, done_nxt;
   logic [7:0] lim;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic; address and data stay put across the whole strobe
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      addr_nxt = fl_addr_o;
      dq_nxt = fl_dq_o;
      rdata_nxt = cyc.rdata;
      dq_oe_nxt = fl_dq_oe_o;
      ce_n_nxt = fl_ce_n_o;
      we_n_nxt = fl_we_n_o;
      oe_n_nxt = fl_oe_n_o;
      done_nxt = 1'b0;
      lim = wr_r ? 8'(flc_pkg::T_WP_CYC) : 8'(flc_pkg::T_ACC_CYC);
      case (st_r)
         E_IDLE: begin
            if (cyc.req) begin
               addr_nxt = cyc.addr;
               dq_nxt = cyc.wdata;
               wr_nxt = cyc.wr;
               dq_oe_nxt = cyc.wr;
               ce_n_nxt = 1'b0;
               cnt_nxt = 8'h00;
               st_nxt = E_SET;
            end
         end
         E_SET: begin
            // oe stays high on writes so the device sees a write cycle
            we_n_nxt = ~wr_r;
            oe_n_nxt = wr_r;
            st_nxt = E_STB;
         end
         E_STB: begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == lim - 8'h01) begin
               we_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               if (!wr_r) begin
                  rdata_nxt = fl_dq_i;
               end
               st_nxt = E_HOLD;
            end
         end
         E_HOLD: begin
            // data held one cycle past we rising for hold time
            ce_n_nxt = 1'b1;
            dq_oe_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = E_IDLE;
         end
         default: st_nxt = E_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= E_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         fl_addr_o <= 19'h00000;
         fl_dq_o <= 8'h00;
         fl_dq_oe_o <= 1'b0;
         fl_ce_n_o <= 1'b1;
         fl_we_n_o <= 1'b1;
         fl_oe_n_o <= 1'b1;
         cyc.done <= 1'b0;
         cyc.rdata <= 8'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         fl_addr_o <= addr_nxt;
         fl_dq_o <= dq_nxt;
         fl_dq_oe_o <= dq_oe_nxt;
         fl_ce_n_o <= ce_n_nxt;
         fl_we_n_o <= we_n_nxt;
         fl_oe_n_o <= oe_n_nxt;
         cyc.done <= done_nxt;
         cyc.rdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write strobe is low for exactly the write pulse width
   AST_WE_WIDTH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(fl_we_n_o) |-> (!fl_we_n_o && fl_dq_oe_o) [*5] ##1 fl_we_n_o)
      else $error("write strobe width wrong");

endmodule : flc_bus_cyc

// *** verilog/flc_cyc_if.sv ***
// request/answer carrier between sequencer and flash bus cycle engine
`timescale 1ns/1ns
interface flc_cyc_if;
   logic req;
   logic wr;
   logic [18:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;

   modport seq (output req, wr, addr, wdata, input done, rdata);
   modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface : flc_cyc_if

// *** verilog/flc_host.sv ***
// flash program/erase host controller: software registers to command sequences
`timescale 1ns/1ns
module flc_host #(
   parameter int WIN_CYC = flc_pkg::T_WIN_CYC
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // software register port
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // flash pins
   output logic [18:0] fl_addr_o,
   output logic [7:0] fl_dq_o,
   output logic fl_dq_oe_o,
   input wire logic [7:0] fl_dq_i,
   output logic fl_ce_n_o,
   output logic fl_we_n_o,
   output logic fl_oe_n_o
);

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT, S_SWAIT} flc_seq_t;

   flc_cyc_if cyc ();

   flc_bus_cyc u_eng (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .cyc(cyc),
      .fl_addr_o(fl_addr_o),
      .fl_dq_o(fl_dq_o),
      .fl_dq_oe_o(fl_dq_oe_o),
      .fl_dq_i(fl_dq_i),
      .fl_ce_n_o(fl_ce_n_o),
      .fl_we_n_o(fl_we_n_o),
      .fl_oe_n_o(fl_oe_n_o)
   );

   flc_seq_t st_r, st_nxt;
   logic [3:0] op_r, op_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [18:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic err_r, err_nxt, chip_r, chip_nxt, sect_r, sect_nxt, susp_r, susp_nxt;
   logic tog_ok_r, tog_ok_nxt, tog_r, tog_nxt, req_r, req_nxt;
   logic [12:0] win_r, win_nxt;
   logic [10:0] wait_r, wait_nxt;
   logic [31:0] rd_nxt;
   logic cmd_wr, legal, win_open, adds_ok;
   logic [3:0] new_op;
   flc_pkg::flc_step_t stp;

   ////////////////////////////////////////////////////////////////////////////
   // one bus cycle of each sequence; single-cycle commands go out at the address register value
   function automatic flc_pkg::flc_step_t step_of(input logic [3:0] op, input logic [2:0] i,
                                                 input logic [18:0] a, input logic [7:0] d);
      flc_pkg::flc_step_t s;
      s = '{wr: 1'b1, addr: flc_pkg::UNLK_ADDR1, data: flc_pkg::D_UNLK1, last: 1'b0};
      case (i)
         3'd1, 3'd4: begin
            s.addr = flc_pkg::UNLK_ADDR2;
            s.data = flc_pkg::D_UNLK2;
         end
         3'd2: s.data = (op == flc_pkg::OP_PROG) ? flc_pkg::D_PROG :
                        (op == flc_pkg::OP_AUTOSEL) ? flc_pkg::D_AUTOSEL : flc_pkg::D_ESETUP;
         3'd3: begin
            if (op == flc_pkg::OP_PROG) begin
               s.addr = a;
               s.data = d;
            end
         end
         3'd5: begin
            s.data = (op == flc_pkg::OP_CHIP) ? flc_pkg::D_CHIP : flc_pkg::D_SECT;
            s.addr = (op == flc_pkg::OP_CHIP) ? flc_pkg::UNLK_ADDR1 : a;
         end
         default: ;
      endcase
      s.last = (op == flc_pkg::OP_PROG && i == 3'd3) || (op == flc_pkg::OP_AUTOSEL && i == 3'd2)
               || i == 3'd5;
      case (op)
         flc_pkg::OP_READ: s = '{wr: 1'b0, addr: a, data: 8'h00, last: 1'b1};
         flc_pkg::OP_ADDS: s = '{wr: 1'b1, addr: a, data: flc_pkg::D_SECT, last: 1'b1};
         flc_pkg::OP_SUSP: s = '{wr: 1'b1, addr: a, data: flc_pkg::D_SUSP, last: 1'b1};
         flc_pkg::OP_RESUME: s = '{wr: 1'b1, addr: a, data: flc_pkg::D_SECT, last: 1'b1};
         flc_pkg::OP_RESET: s = '{wr: 1'b1, addr: a, data: flc_pkg::D_RESET, last: 1'b1};
         default: ;
      endcase
      return s;
   endfunction : step_of

   ////////////////////////////////////////////////////////////////////////////
   // which operations the host may start from what it knows of the device
   assign cmd_wr = reg_wr_i && reg_addr_i == flc_pkg::OFF_CMD;
   assign new_op = reg_wdata_i[3:0];
   assign win_open = win_r != 13'h0000;
   // extra sector writes only with margin left, so the device never drops one
   assign adds_ok = sect_r && !susp_r && win_r > 13'(flc_pkg::WIN_GUARD_CYC);
   assign stp = step_of(op_r, idx_r, addr_r, wdata_r);

   always_comb begin
      case (new_op)
         flc_pkg::OP_READ: legal = 1'b1;
         flc_pkg::OP_PROG, flc_pkg::OP_AUTOSEL, flc_pkg::OP_RESET:
            legal = !chip_r && (!sect_r || susp_r || win_open);
         flc_pkg::OP_CHIP, flc_pkg::OP_SECT: legal = !chip_r && !sect_r;
         flc_pkg::OP_ADDS: legal = adds_ok;
         flc_pkg::OP_SUSP: legal = sect_r && !susp_r;
         flc_pkg::OP_RESUME: legal = susp_r;
         default: legal = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and device tracking
   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      chip_nxt = chip_r;
      sect_nxt = sect_r;
      susp_nxt = susp_r;
      tog_ok_nxt = tog_ok_r;
      tog_nxt = tog_r;
      req_nxt = 1'b0;
      win_nxt = win_open ? win_r - 13'h0001 : win_r;
      wait_nxt = (wait_r != 11'h000) ? wait_r - 11'h001 : wait_r;
      if (reg_wr_i && reg_addr_i == flc_pkg::OFF_ADDR) begin
         addr_nxt = reg_wdata_i[18:0];
      end
      if (reg_wr_i && reg_addr_i == flc_pkg::OFF_WDATA) begin
         wdata_nxt = reg_wdata_i[7:0];
      end
      if (reg_wr_i && reg_addr_i == flc_pkg::OFF_STAT && reg_wdata_i[flc_pkg::ST_ERR]) begin
         err_nxt = 1'b0;
      end
      case (st_r)
         S_IDLE: begin
            if (cmd_wr) begin
               if (legal) begin
                  op_nxt = new_op;
                  idx_nxt = 3'd0;
                  req_nxt = 1'b1;
                  st_nxt = S_REQ;
               end else begin
                  err_nxt = 1'b1; // refusal outranks clear in the same cycle
               end
            end
         end
         S_REQ: st_nxt = S_WAIT;
         S_WAIT: begin
            if (cyc.done) begin
               if (!stp.last) begin
                  idx_nxt = idx_r + 3'd1;
                  req_nxt = 1'b1;
                  st_nxt = S_REQ;
               end else begin
                  st_nxt = S_IDLE;
                  tog_ok_nxt = 1'b0;
                  case (op_r)
                     flc_pkg::OP_READ: begin
                        rdata_nxt = cyc.rdata;
                        tog_nxt = cyc.rdata[flc_pkg::TOGGLE_BIT];
                        tog_ok_nxt = 1'b1;
                        // two reads with equal toggle bit: algorithm has ended
                        if (tog_ok_r && tog_r == cyc.rdata[flc_pkg::TOGGLE_BIT] && !susp_r
                            && !win_open) begin
                           chip_nxt = 1'b0;
                           sect_nxt = 1'b0;
                        end
                     end
                     flc_pkg::OP_CHIP: chip_nxt = 1'b1;
                     flc_pkg::OP_SECT, flc_pkg::OP_ADDS: begin
                        sect_nxt = 1'b1;
                        win_nxt = 13'(WIN_CYC);
                     end
                     flc_pkg::OP_SUSP: begin
                        susp_nxt = 1'b1;
                        win_nxt = 13'h0000;
                        // window suspends at once; a running erase needs time
                        if (!win_open) begin
                           wait_nxt = 11'(flc_pkg::T_SUSP_CYC);
                           st_nxt = S_SWAIT;
                        end
                     end
                     flc_pkg::OP_RESUME: susp_nxt = 1'b0;
                     default: begin
                        // any other write inside the window aborts the erase
                        if (sect_r && !susp_r) begin
                           sect_nxt = 1'b0;
                           win_nxt = 13'h0000;
                        end
                     end
                  endcase
               end
            end
         end
         S_SWAIT: begin
            if (wait_r == 11'h000) begin
               st_nxt = S_IDLE;
            end
         end
         default: st_nxt = S_IDLE;
      endcase
      if (cmd_wr && st_r != S_IDLE) begin
         err_nxt = 1'b1;
      end
   end

   assign cyc.req = req_r;
   assign cyc.wr = stp.wr;
   assign cyc.addr = stp.addr;
   assign cyc.wdata = stp.data;

   // register read mux, answer stands the cycle after the strobe only
   always_comb begin
      rd_nxt = 32'h00000000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            flc_pkg::OFF_ADDR: rd_nxt = {13'h0000, addr_r};
            flc_pkg::OFF_WDATA: rd_nxt = {24'h000000, wdata_r};
            flc_pkg::OFF_STAT: rd_nxt = {26'h0000000, susp_r, win_open, sect_r, chip_r,
                                         err_r, st_r != S_IDLE};
            flc_pkg::OFF_RDATA: rd_nxt = {24'h000000, rdata_r};
            default: rd_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= S_IDLE;
         op_r <= 4'h0;
         idx_r <= 3'd0;
         addr_r <= 19'h00000;
         wdata_r <= 8'h00;
         rdata_r <= 8'h00;
         err_r <= 1'b0;
         chip_r <= 1'b0;
         sect_r <= 1'b0;
         susp_r <= 1'b0;
         tog_ok_r <= 1'b0;
         tog_r <= 1'b0;
         req_r <= 1'b0;
         win_r <= 13'h0000;
         wait_r <= 11'h000;
         reg_rdata_o <= 32'h00000000;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
         chip_r <= chip_nxt;
         sect_r <= sect_nxt;
         susp_r <= susp_nxt;
         tog_ok_r <= tog_ok_nxt;
         tog_r <= tog_nxt;
         req_r <= req_nxt;
         win_r <= win_nxt;
         wait_r <= wait_nxt;
         reg_rdata_o <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the emitted command sequences
   AST_UNLOCK_FIRST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      req_r && idx_r == 3'd0 && (op_r == flc_pkg::OP_PROG || op_r == flc_pkg::OP_CHIP)
      |-> ##3 fl_addr_o == 19'h00555 && fl_dq_o == 8'haa && !fl_we_n_o)
      else $error("first unlock write wrong");
   AST_PROG_SETUP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      req_r && op_r == flc_pkg::OP_PROG && idx_r == 3'd3
      |-> $past(fl_dq_o) == 8'ha0 ##2 fl_addr_o == addr_r && fl_dq_o == wdata_r)
      else $error("program sequence wrong");
   AST_CHIP_LAST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      req_r && op_r == flc_pkg::OP_CHIP && idx_r == 3'd5
      |-> ##2 fl_dq_o == 8'h10 && fl_addr_o == 19'h00555)
      else $error("chip erase command wrong");
   AST_SECT_LAST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      req_r && op_r == flc_pkg::OP_SECT && idx_r == 3'd5
      |-> ##2 fl_dq_o == 8'h30 && fl_addr_o == addr_r)
      else $error("sector erase command wrong");
   AST_ADDS_GAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      req_r && op_r == flc_pkg::OP_ADDS |-> ##[1:12] cyc.done ##0 win_r != 13'h0000)
      else $error("extra sector write outside window");
   AST_CHIP_REFUSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cmd_wr && st_r == S_IDLE && chip_r && new_op != flc_pkg::OP_READ
      |=> err_r && st_r == S_IDLE)
      else $error("command issued during chip erase");
   C_PROG: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cyc.done && op_r == flc_pkg::OP_PROG && stp.last);
   C_ADDS: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cyc.done && op_r == flc_pkg::OP_ADDS);
   C_SUSP: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(susp_r));

endmodule : flc_host

// *** verilog/flc_pkg.sv ***
// constants shared by the flash program/erase host controller
package flc_pkg;

   // software register offsets (byte addresses)
   localparam logic [4:0] OFF_CMD = 5'h00;
   localparam logic [4:0] OFF_ADDR = 5'h04;
   localparam logic [4:0] OFF_WDATA = 5'h08;
   localparam logic [4:0] OFF_STAT = 5'h0c;
   localparam logic [4:0] OFF_RDATA = 5'h10;

   // operation codes written to the command register
   localparam logic [3:0] OP_READ = 4'h1;
   localparam logic [3:0] OP_PROG = 4'h2;
   localparam logic [3:0] OP_CHIP = 4'h3;
   localparam logic [3:0] OP_SECT = 4'h4;
   localparam logic [3:0] OP_ADDS = 4'h5;
   localparam logic [3:0] OP_SUSP = 4'h6;
   localparam logic [3:0] OP_RESUME = 4'h7;
   localparam logic [3:0] OP_RESET = 4'h8;
   localparam logic [3:0] OP_AUTOSEL = 4'h9;

   // status register bit positions, and the device data toggle bit
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam int ST_CHIP = 2;
   localparam int ST_SECT = 3;
   localparam int ST_WIN = 4;
   localparam int ST_SUSP = 5;
   localparam int TOGGLE_BIT = 6;

   // flash command cycle addresses and data
   localparam logic [18:0] UNLK_ADDR1 = 19'h00555;
   localparam logic [18:0] UNLK_ADDR2 = 19'h002aa;
   localparam logic [7:0] D_UNLK1 = 8'haa;
   localparam logic [7:0] D_UNLK2 = 8'h55;
   localparam logic [7:0] D_ESETUP = 8'h80;
   localparam logic [7:0] D_CHIP = 8'h10;
   localparam logic [7:0] D_SECT = 8'h30;
   localparam logic [7:0] D_PROG = 8'ha0;
   localparam logic [7:0] D_SUSP = 8'hb0;
   localparam logic [7:0] D_RESET = 8'hf0;
   localparam logic [7:0] D_AUTOSEL = 8'h90;

   // timing
   localparam int CLK_NS = 10;
   localparam int T_WP_NS = 50;
   localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACC_NS = 120;
   localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WIN_US = 50;
   localparam int T_WIN_CYC = (T_WIN_US * 1000) / CLK_NS;
   localparam int T_SUSP_US = 20;
   localparam int T_SUSP_CYC = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int WIN_GUARD_CYC = 16;

   // one bus cycle of a command sequence
   typedef struct packed {
      logic wr;
      logic [18:0] addr;
      logic [7:0] data;
      logic last;
   } flc_step_t;

endpackage : flc_pkg
